// *** common/uart_flc_pkg.sv ***
/*
  Types of the UART FIFO and line-format control block.
  Assumes nothing of its surroundings.
*/
package uart_flc_pkg;

  typedef enum logic [1:0] {
    TBL_A = 2'h0,
    TBL_B = 2'h1,
    TBL_C = 2'h2,
    TBL_D = 2'h3
  } table_t;

  typedef logic [6:0] level_t;

endpackage

// *** common/uart_flc_regs.svh ***
/*
  Register indices, field positions, reset values and levels of the UART
  FIFO and line-format control block.
  Assumes it is included by its bare name.
*/
`ifndef UART_FLC_REGS_SVH
`define UART_FLC_REGS_SVH

`define UFL_IDX_DIV_LO     4'h0
`define UFL_IDX_DIV_HI     4'h1
`define UFL_IDX_FIFO_CTRL  4'h2
`define UFL_IDX_LINE_FMT   4'h3
`define UFL_IDX_MODEM_CTRL 4'h4
`define UFL_IDX_TRIG_TBL   4'h8
`define UFL_IDX_ENH_FEAT   4'h9
`define UFL_IDX_RX_PROG    4'hA
`define UFL_IDX_TX_PROG    4'hB
`define UFL_IDX_STATUS     4'hC

`define UFL_RST_FIFO_CTRL  8'h00
`define UFL_RST_LINE_FMT   8'h1D
`define UFL_RST_MODEM_CTRL 8'h00
`define UFL_RST_OTHER      8'h00

`define UFL_ENH_UNLOCK     4
`define UFL_ENH_AUTO_RTS   6
`define UFL_ENH_SW_FLOW    3
`define UFL_MCR_PRESCALE   7
`define UFL_MCR_TRIG_ACC   6

`define UFL_DEPTH_ON       7'h40
`define UFL_DEPTH_OFF      7'h01
`define UFL_HALT_MAX       8'h3C
`define UFL_PRESCALE_LAST  2'h3
`define UFL_STOP_ONE       3'h2
`define UFL_STOP_ONE_HALF  3'h3
`define UFL_STOP_TWO       3'h4

`endif

// *** logic/uart_fifo_line_control.sv ***
/*
  FIFO control and line-format control of one UART channel, with an
  Avalon-MM register slave.
  Assumes fill counts and serial data come from logic on CLOCK.
*/
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "uart_flc_regs.svh"

module uart_fifo_line_control (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Avalon-MM slave
  input  wire logic [5:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [3:0]  BYTEENABLE,
  input  wire logic [31:0] WRITEDATA,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  // FIFO side
  input  wire logic [6:0]  RX_FILL,
  input  wire logic [6:0]  TX_FILL,
  output logic             RX_FIFO_CLR,
  output logic             TX_FIFO_CLR,
  output logic             FIFO_ENABLE,
  output logic      [6:0]  FIFO_DEPTH,
  output logic      [6:0]  RX_TRIGGER,
  output logic      [6:0]  TX_TRIGGER,
  output logic             RX_TRIG_HIT,
  output logic             TX_TRIG_HIT,
  output logic             DMA_MODE,
  output logic             RX_DMA_REQ,
  output logic             TX_DMA_REQ,
  // Flow control
  output logic             RTS_HALT,
  output logic             XOFF_REQ,
  output logic             XON_REQ,
  // Line format
  input  wire logic        TX_SERIAL,
  output logic             TXD,
  input  wire logic [7:0]  TX_CHAR,
  output logic             TX_PARITY,
  input  wire logic [7:0]  RX_CHAR,
  input  wire logic        RX_PARITY,
  output logic             RX_PARITY_ERR,
  output logic             PARITY_ENABLE,
  output logic      [3:0]  WORD_BITS,
  output logic      [2:0]  STOP_HALF_BITS,
  output logic      [15:0] DIVISOR,
  output logic             PRESCALE_TICK
);

  // Receive table: index 0 is empty, 1..4 the levels, 5 the full FIFO
  function automatic uart_flc_pkg::level_t rx_tbl(
    input uart_flc_pkg::table_t t,
    input logic [2:0]           i
  );
    logic [6:0] v;
    v = 7'h00;
    case (i)
      3'h1: v = (t == uart_flc_pkg::TBL_A) ? 7'h01 : 7'h08;
      3'h2: v = (t == uart_flc_pkg::TBL_A) ? 7'h04 : 7'h10;
      3'h3: v = (t == uart_flc_pkg::TBL_A) ? 7'h08 :
                (t == uart_flc_pkg::TBL_B) ? 7'h18 : 7'h38;
      3'h4: v = (t == uart_flc_pkg::TBL_A) ? 7'h0E :
                (t == uart_flc_pkg::TBL_B) ? 7'h1C : 7'h3C;
      3'h5: v = `UFL_DEPTH_ON;
      default: v = 7'h00;
    endcase
    return v;
  endfunction

  function automatic uart_flc_pkg::level_t tx_tbl(
    input uart_flc_pkg::table_t t,
    input logic [1:0]           c
  );
    logic [6:0] v;
    v = 7'h01;
    case (t)
      uart_flc_pkg::TBL_B:
        case (c)
          2'h0:    v = 7'h10;
          2'h1:    v = 7'h08;
          2'h2:    v = 7'h18;
          default: v = 7'h1E;
        endcase
      uart_flc_pkg::TBL_C:
        case (c)
          2'h0:    v = 7'h08;
          2'h1:    v = 7'h10;
          2'h2:    v = 7'h20;
          default: v = 7'h38;
        endcase
      default: v = 7'h01;
    endcase
    return v;
  endfunction

  // Parity bit for a character of the programmed length
  function automatic logic parity_of(
    input logic [7:0] d,
    input logic [7:0] lf
  );
    logic [7:0] m;
    logic       p;
    m = d & (8'hFF >> (2'h3 - lf[1:0]));
    p = lf[4] ? (^m) : ~(^m);
    if (lf[5])
    begin
      p = ~lf[4];
    end
    return p;
  endfunction

  logic [7:0]  div_lo_r;
  logic [7:0]  div_hi_r;
  logic [7:0]  fifo_ctrl_r;
  logic [7:0]  line_fmt_r;
  logic [7:0]  modem_ctrl_r;
  logic [7:0]  trig_tbl_r;
  logic [7:0]  enh_feat_r;
  logic [7:0]  rx_prog_r;
  logic [7:0]  tx_prog_r;
  logic        waitreq_r;
  logic [31:0] rdata_r;
  logic        rx_clr_r;
  logic        tx_clr_r;
  logic        hw_halt_r;
  logic        sw_halt_r;
  logic        xoff_r;
  logic        xon_r;
  logic [1:0]  pre_cnt_r;
  logic        tick_r;
  logic        txd_r;
  logic        tx_par_r;
  logic        rx_perr_r;
  logic [6:0]  rx_trig_r;
  logic [6:0]  tx_trig_r;
  logic        rx_hit_r;
  logic        tx_hit_r;

  // Bus decode
  wire  [3:0]  idx      = ADDRESS[5:2];
  wire         dlab     = line_fmt_r[7];
  wire         trig_acc = modem_ctrl_r[`UFL_MCR_TRIG_ACC];
  wire         unlock   = enh_feat_r[`UFL_ENH_UNLOCK];
  wire         wr_go    = WRITE & ~waitreq_r & BYTEENABLE[0];
  wire         rd_cap   = READ & waitreq_r;
  wire  [7:0]  wd       = WRITEDATA[7:0];
  wire         sel_dlo  = (idx == `UFL_IDX_DIV_LO) & dlab;
  wire         sel_dhi  = (idx == `UFL_IDX_DIV_HI) & dlab;
  wire         sel_fcr  = (idx == `UFL_IDX_FIFO_CTRL) & ~dlab;
  wire         sel_lcr  = (idx == `UFL_IDX_LINE_FMT);
  wire         sel_mcr  = (idx == `UFL_IDX_MODEM_CTRL) & ~dlab;
  wire         sel_tbl  = (idx == `UFL_IDX_TRIG_TBL);
  wire         sel_enh  = (idx == `UFL_IDX_ENH_FEAT);
  wire         sel_rxp  = (idx == `UFL_IDX_RX_PROG) & trig_acc;
  wire         sel_txp  = (idx == `UFL_IDX_TX_PROG) & trig_acc;
  wire         sel_st   = (idx == `UFL_IDX_STATUS);
  wire         fcr_wr   = wr_go & sel_fcr;
  wire         fcr_open = wd[0];

  wire  [7:0]  status   = {4'h0, tx_hit_r, rx_hit_r, sw_halt_r, hw_halt_r};
  wire  [7:0]  rd_mux   = sel_dlo ? div_lo_r :
                          sel_dhi ? div_hi_r :
                          sel_lcr ? line_fmt_r :
                          sel_mcr ? modem_ctrl_r :
                          sel_tbl ? trig_tbl_r :
                          sel_enh ? enh_feat_r :
                          sel_rxp ? rx_prog_r :
                          sel_txp ? tx_prog_r :
                          sel_st  ? status : 8'h00;

  // Next fifo_control value; writes with bit 0 low touch only bit 0
  wire  [1:0]  tx_code_wr = unlock ? wd[5:4] : fifo_ctrl_r[5:4];
  wire  [7:0]  fcr_nxt    = fcr_open ?
                            {wd[7:6], tx_code_wr, wd[3], 2'h0, 1'b1} :
                            {fifo_ctrl_r[7:1], 1'b0};
  wire  [7:0]  mcr_nxt    = unlock ? wd : {modem_ctrl_r[7:5], wd[4:0]};

  // Trigger selection
  wire                      fifo_en = fifo_ctrl_r[0];
  wire uart_flc_pkg::table_t tbl    = uart_flc_pkg::table_t'(trig_tbl_r[5:4]);
  wire         tbl_d    = (tbl == uart_flc_pkg::TBL_D);
  wire  [2:0]  rx_idx   = {1'b0, fifo_ctrl_r[7:6]} + 3'h1;
  wire  [1:0]  tx_code  = unlock ? fifo_ctrl_r[5:4] : 2'h0;
  wire  [6:0]  prog_rx  = {1'b0, rx_prog_r[5:0]};
  wire  [6:0]  hyst     = {3'h0, trig_tbl_r[3:0]};
  wire  [6:0]  depth    = fifo_en ? `UFL_DEPTH_ON : `UFL_DEPTH_OFF;
  wire  [6:0]  rx_trig  = ~fifo_en ? `UFL_DEPTH_OFF :
                          tbl_d ? prog_rx :
                          rx_tbl(tbl, rx_idx);
  wire  [6:0]  tx_trig  = ~fifo_en ? `UFL_DEPTH_OFF :
                          tbl_d ? {1'b0, tx_prog_r[5:0]} :
                          tx_tbl(tbl, tx_code);

  // Flow thresholds
  wire  [7:0]  d_sum    = {1'b0, prog_rx} + {1'b0, hyst};
  wire  [6:0]  d_halt   = (d_sum > `UFL_HALT_MAX) ?
                          7'(`UFL_HALT_MAX) : d_sum[6:0];
  wire  [6:0]  d_resume = (prog_rx > hyst) ? (prog_rx - hyst) : 7'h00;
  wire  [6:0]  halt_lvl = tbl_d ? d_halt :
                          rx_tbl(tbl, rx_idx + 3'h1);
  wire  [6:0]  res_lvl  = tbl_d ? d_resume :
                          rx_tbl(tbl, rx_idx - 3'h1);
  wire         auto_rts = enh_feat_r[`UFL_ENH_AUTO_RTS];
  wire         sw_flow  = enh_feat_r[`UFL_ENH_SW_FLOW];
  wire         at_halt  = RX_FILL >= halt_lvl;
  wire         at_res   = RX_FILL <= res_lvl;
  wire         sw_set   = sw_flow & ~sw_halt_r & (RX_FILL == rx_trig);
  wire         sw_rel   = sw_halt_r & at_res & ~sw_set;
  wire         hw_nxt   = ~auto_rts ? 1'b0 :
                          at_halt ? 1'b1 :
                          at_res ? 1'b0 : hw_halt_r;

  // Level comparison and line helpers
  wire  [6:0]  tx_space = depth - TX_FILL;
  wire         rx_hit   = RX_FILL >= rx_trig;
  wire         tx_hit   = tx_space >= tx_trig;
  wire         div4     = modem_ctrl_r[`UFL_MCR_PRESCALE];
  wire         tick_nxt = ~div4 | (pre_cnt_r == `UFL_PRESCALE_LAST);
  wire         par_en   = line_fmt_r[3];
  wire  [2:0]  stop_hb  = ~line_fmt_r[2] ? `UFL_STOP_ONE :
                          (line_fmt_r[1:0] == 2'h0) ? `UFL_STOP_ONE_HALF :
                          `UFL_STOP_TWO;
  wire         rx_perr  = par_en & (parity_of(RX_CHAR, line_fmt_r) != RX_PARITY);

  // Avalon answer: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      waitreq_r <= ~((READ | WRITE) & waitreq_r);
      if (rd_cap)
      begin
        rdata_r <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      div_lo_r     <= `UFL_RST_OTHER;
      div_hi_r     <= `UFL_RST_OTHER;
      fifo_ctrl_r  <= `UFL_RST_FIFO_CTRL;
      line_fmt_r   <= `UFL_RST_LINE_FMT;
      modem_ctrl_r <= `UFL_RST_MODEM_CTRL;
      trig_tbl_r   <= `UFL_RST_OTHER;
      enh_feat_r   <= `UFL_RST_OTHER;
      rx_prog_r    <= `UFL_RST_OTHER;
      tx_prog_r    <= `UFL_RST_OTHER;
    end
    else if (wr_go)
    begin
      if (sel_dlo) div_lo_r <= wd;
      if (sel_dhi) div_hi_r <= wd;
      if (sel_fcr) fifo_ctrl_r <= fcr_nxt;
      if (sel_lcr) line_fmt_r <= wd;
      if (sel_mcr) modem_ctrl_r <= mcr_nxt;
      if (sel_tbl) trig_tbl_r <= wd;
      if (sel_enh) enh_feat_r <= wd;
      if (sel_rxp) rx_prog_r <= wd;
      if (sel_txp) tx_prog_r <= wd;
    end
  end

  // FIFO clear pulses last one cycle; the stored bits stay zero
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rx_clr_r <= 1'b0;
      tx_clr_r <= 1'b0;
    end
    else
    begin
      rx_clr_r <= fcr_wr & fcr_open & wd[1];
      tx_clr_r <= fcr_wr & fcr_open & wd[2];
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      hw_halt_r <= 1'b0;
      sw_halt_r <= 1'b0;
      xoff_r    <= 1'b0;
      xon_r     <= 1'b0;
    end
    else
    begin
      hw_halt_r <= hw_nxt;
      sw_halt_r <= sw_set | (sw_halt_r & ~sw_rel);
      xoff_r    <= sw_set;
      xon_r     <= sw_rel;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rx_trig_r <= `UFL_DEPTH_OFF;
      tx_trig_r <= `UFL_DEPTH_OFF;
      rx_hit_r  <= 1'b0;
      tx_hit_r  <= 1'b0;
    end
    else
    begin
      rx_trig_r <= rx_trig;
      tx_trig_r <= tx_trig;
      rx_hit_r  <= rx_hit;
      tx_hit_r  <= tx_hit;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      pre_cnt_r <= 2'h0;
      tick_r    <= 1'b0;
      txd_r     <= 1'b1;
      tx_par_r  <= 1'b0;
      rx_perr_r <= 1'b0;
    end
    else
    begin
      pre_cnt_r <= div4 ? pre_cnt_r + 2'h1 : 2'h0;
      tick_r    <= tick_nxt;
      txd_r     <= TX_SERIAL & ~line_fmt_r[6];
      tx_par_r  <= par_en & parity_of(TX_CHAR, line_fmt_r);
      rx_perr_r <= rx_perr;
    end
  end

  // Outputs; the configuration registers themselves are flip-flops
  assign READDATA       = rdata_r;
  assign WAITREQUEST    = waitreq_r;
  assign RX_FIFO_CLR    = rx_clr_r;
  assign TX_FIFO_CLR    = tx_clr_r;
  assign FIFO_ENABLE    = fifo_ctrl_r[0];
  assign FIFO_DEPTH     = fifo_ctrl_r[0] ? `UFL_DEPTH_ON : `UFL_DEPTH_OFF;
  assign RX_TRIGGER     = rx_trig_r;
  assign TX_TRIGGER     = tx_trig_r;
  assign RX_TRIG_HIT    = rx_hit_r;
  assign TX_TRIG_HIT    = tx_hit_r;
  assign DMA_MODE       = fifo_ctrl_r[3];
  assign RX_DMA_REQ     = fifo_ctrl_r[3] & rx_hit_r;
  assign TX_DMA_REQ     = fifo_ctrl_r[3] & tx_hit_r;
  assign RTS_HALT       = hw_halt_r;
  assign XOFF_REQ       = xoff_r;
  assign XON_REQ        = xon_r;
  assign TXD            = txd_r;
  assign TX_PARITY      = tx_par_r;
  assign RX_PARITY_ERR  = rx_perr_r;
  assign PARITY_ENABLE  = line_fmt_r[3];
  assign WORD_BITS      = {2'h1, line_fmt_r[1:0]} + 4'h1;
  assign STOP_HALF_BITS = stop_hb;
  assign DIVISOR        = {div_hi_r, div_lo_r};
  assign PRESCALE_TICK  = tick_r;

endmodule // uart_fifo_line_control

// *** tb/tb.sv ***
/*
  Self-checking bench of the UART FIFO and line-format control block.
  Assumes the checker binds itself and the remote model drives the FIFO side.
*/
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [3:0] s; logic [31:0] v;} note_t;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic        READ = 1'b0;
  logic        WRITE = 1'b0;
  logic [5:0]  ADDRESS = 6'h00;
  logic [3:0]  BYTEENABLE = 4'hF;
  logic [31:0] WRITEDATA = 32'h0;
  logic [7:0]  TX_CHAR = 8'h00;
  logic [6:0]  goal = 7'h00;
  logic        slow = 1'b0;
  logic        probe = 1'b0;
  logic [31:0] seen = 32'h0;
  logic [31:0] n_clr = 32'h0;
  logic [31:0] n_xon = 32'h0;
  integer      seed = 32'h79DF;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  note_t       q[$];
  note_t       nt;
  logic [6:0]  rxl[12] = '{7'h01, 7'h04, 7'h08, 7'h0E, 7'h08, 7'h10, 7'h18, 7'h1C, 7'h08,
                           7'h10, 7'h38, 7'h3C};
  logic [6:0]  txl[12] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h10, 7'h08, 7'h18, 7'h1E, 7'h08,
                           7'h10, 7'h20, 7'h38};
  wire  [31:0] READDATA;
  wire  [15:0] DIVISOR;
  wire  [7:0]  RX_CHAR;
  wire  [6:0]  RX_FILL, TX_FILL, FIFO_DEPTH, RX_TRIGGER, TX_TRIGGER;
  wire  [3:0]  WORD_BITS;
  wire  [2:0]  STOP_HALF_BITS;
  wire         WAITREQUEST, RX_FIFO_CLR, TX_FIFO_CLR, FIFO_ENABLE, RX_TRIG_HIT, TX_TRIG_HIT;
  wire         DMA_MODE, RX_DMA_REQ, TX_DMA_REQ, RTS_HALT, XOFF_REQ, XON_REQ, TX_SERIAL, TXD;
  wire         TX_PARITY, RX_PARITY, RX_PARITY_ERR, PARITY_ENABLE, PRESCALE_TICK;

  uart_fifo_line_control dut (.CLOCK, .RST, .ADDRESS, .READ, .WRITE, .BYTEENABLE, .WRITEDATA,
    .READDATA, .WAITREQUEST, .RX_FILL, .TX_FILL, .RX_FIFO_CLR, .TX_FIFO_CLR, .FIFO_ENABLE,
    .FIFO_DEPTH, .RX_TRIGGER, .TX_TRIGGER, .RX_TRIG_HIT, .TX_TRIG_HIT, .DMA_MODE, .RX_DMA_REQ,
    .TX_DMA_REQ, .RTS_HALT, .XOFF_REQ, .XON_REQ, .TX_SERIAL, .TXD, .TX_CHAR, .TX_PARITY,
    .RX_CHAR, .RX_PARITY, .RX_PARITY_ERR, .PARITY_ENABLE, .WORD_BITS, .STOP_HALF_BITS,
    .DIVISOR, .PRESCALE_TICK);
  uart_flc_remote far (.CLOCK, .RST, .goal, .slow, .RTS_HALT, .RX_FILL, .TX_FILL,
    .TX_SERIAL, .RX_CHAR, .RX_PARITY);

  initial
    forever
      #2.5 CLOCK = ~CLOCK;

  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = READDATA;
      4'h1: obs = {PARITY_ENABLE, TX_PARITY, WORD_BITS, STOP_HALF_BITS};
      4'h2: obs = {RX_TRIGGER, TX_TRIGGER};
      4'h3: obs = RTS_HALT;
      4'h4: obs = DMA_MODE;
      4'h5: obs = {FIFO_ENABLE, FIFO_DEPTH};
      4'h6: obs = DIVISOR;
      4'h7: obs = TXD;
      4'h9: obs = n_clr;
      4'hA: obs = n_xon;
      default: obs = seen;
    endcase
  endfunction

  // Expected format outputs for a line_control value and character
  function automatic logic [8:0] fmt(input logic [5:0] f, input logic [7:0] d);
    logic [7:0] m;
    logic       p;
    m = d & (8'hFF >> (2'h3 - f[1:0]));
    p = f[5] ? !f[4] : (f[4] ? ^m : !(^m));
    fmt = {f[3], f[3] & p, 4'h5 + f[1:0], f[2] ? (f[1:0] == 2'h0 ? 3'h3 : 3'h4) : 3'h2};
  endfunction

  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    READ      <= !w;
    WRITE     <= w;
    ADDRESS   <= {i, 2'h0};
    WRITEDATA <= {24'($random(seed)), d};
    @(posedge CLOCK);
    while (WAITREQUEST !== 1'b0)
      @(posedge CLOCK);
    READ  <= 1'b0;
    WRITE <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    q.push_back('{4'h0, {24'h0, e}});
    bus(1'b0, i, 8'h00);
  endtask

  task automatic look(input logic [3:0] s, input logic [31:0] e);
    q.push_back('{s, e});
    probe <= 1'b1;
    @(posedge CLOCK);
    probe <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic ticks(input logic [31:0] e);
    seen = 32'h0;
    repeat (40)
    begin
      @(posedge CLOCK);
      seen += PRESCALE_TICK;
    end
    look(4'h8, e);
  endtask

  task automatic fill(input logic [6:0] g, input logic e);
    goal <= g;
    for (int i = 0; i < 200 && RX_FILL !== g; i++)
      @(posedge CLOCK);
    repeat (3) @(posedge CLOCK);
    look(4'h3, e);
  endtask

  // Result watcher
  always @(posedge CLOCK)
  begin
    n_clr += RX_FIFO_CLR & TX_FIFO_CLR;
    n_xon += XON_REQ;
    if ((READ && WAITREQUEST === 1'b0) || probe)
    begin
      nt = q.pop_front();
      chk(obs(nt.s), nt.v);
    end
  end

  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (10) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(4'h3, 8'h1D);
    rd(4'h2, 8'h00);
    rd(4'hE, 8'h00);
    wr(4'h4, 8'h80);
    rd(4'h4, 8'h00);
    ticks(32'd40);
    wr(4'h9, 8'h10);
    wr(4'h4, 8'h80);
    ticks(32'd10);
    wr(4'h4, 8'h40);
    for (int k = 0; k < 64; k++)
    begin
      TX_CHAR <= 8'($random(seed));
      wr(4'h3, 8'(k));
      look(4'h1, fmt(k[5:0], TX_CHAR));
    end
    wr(4'h3, 8'h83);
    wr(4'h0, 8'hA5);
    wr(4'h1, 8'h3C);
    rd(4'h1, 8'h3C);
    look(4'h6, 32'h3CA5);
    wr(4'h2, 8'h01);
    look(4'h5, 32'h01);
    wr(4'h3, 8'h43);
    look(4'h7, 32'h0);
    wr(4'h3, 8'h03);
    for (int t = 0; t < 12; t++)
    begin
      wr(4'h8, {2'h0, 2'(t >> 2), 4'h0});
      wr(4'h2, {2'(t), 2'(t), 4'h1});
      look(4'h2, {rxl[t], txl[t]});
    end
    wr(4'h9, 8'h00);
    wr(4'h2, 8'h79);
    look(4'h2, {7'h10, 7'h08});
    look(4'h4, 32'h1);
    wr(4'h9, 8'h58);
    wr(4'h2, 8'h0F);
    look(4'h9, 32'h1);
    wr(4'h2, 8'hC8);
    look(4'h5, 32'h01);
    look(4'h2, {7'h01, 7'h01});
    look(4'h4, 32'h1);
    look(4'h9, 32'h1);
    wr(4'h2, 8'h01);
    look(4'h4, 32'h0);
    slow <= 1'b1;
    wr(4'h8, 8'h10);
    wr(4'h2, 8'h41);
    fill(7'h1E, 1'b1);
    fill(7'h0C, 1'b1);
    fill(7'h08, 1'b0);
    slow <= 1'b0;
    wr(4'h8, 8'h35);
    wr(4'hA, 8'h14);
    wr(4'hB, 8'h0C);
    look(4'h2, {7'h14, 7'h0C});
    fill(7'h28, 1'b1);
    fill(7'h10, 1'b1);
    fill(7'h0F, 1'b0);
    wr(4'hA, 8'h3A);
    fill(7'h3B, 1'b0);
    fill(7'h40, 1'b1);
    wr(4'hA, 8'h03);
    fill(7'h01, 1'b1);
    fill(7'h00, 1'b0);
    look(4'hA, 32'h3);
    wrap_up();
  end
endmodule // tb

// *** tb/uart_flc_props.sv ***
/*
  Concurrent checks of the UART FIFO and line-format control block.
  Assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/1ps
module uart_flc_props (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // Register bus
  input wire logic [5:0]  ADDRESS,
  input wire logic        WRITE,
  input wire logic [3:0]  BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  input wire logic        WAITREQUEST,
  // FIFO side
  input wire logic [6:0]  RX_FILL,
  input wire logic        RX_FIFO_CLR,
  input wire logic        TX_FIFO_CLR,
  input wire logic        FIFO_ENABLE,
  input wire logic [6:0]  FIFO_DEPTH,
  input wire logic [6:0]  RX_TRIGGER,
  input wire logic [6:0]  TX_TRIGGER,
  input wire logic        RX_TRIG_HIT,
  input wire logic        TX_TRIG_HIT,
  input wire logic        DMA_MODE,
  input wire logic        RX_DMA_REQ,
  input wire logic        TX_DMA_REQ,
  // Flow control and line
  input wire logic        RTS_HALT,
  input wire logic        XOFF_REQ,
  input wire logic        TX_SERIAL,
  input wire logic        TXD,
  input wire logic        PRESCALE_TICK
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Enabled write to the fifo_control index accepted on the bus at this edge, whatever the divisor latch bit
  wire fc_wr = WRITE && !WAITREQUEST && BYTEENABLE[0] && WRITEDATA[0] && ADDRESS[5:2] == 4'h2;

  chk_rx_clear: assert property (RX_FIFO_CLR |-> $past(fc_wr && WRITEDATA[1]) ##1 !RX_FIFO_CLR)
    else $error("receive clear pulse wrong");
  chk_tx_clear: assert property (TX_FIFO_CLR |-> $past(fc_wr && WRITEDATA[2]) ##1 !TX_FIFO_CLR)
    else $error("transmit clear pulse wrong");
  chk_depth_sel: assert property (FIFO_DEPTH == (FIFO_ENABLE ? 7'h40 : 7'h01))
    else $error("depth does not follow enable");
  chk_off_level: assert property (!FIFO_ENABLE [*2] |-> RX_TRIGGER == 7'h01 && TX_TRIGGER == 7'h01)
    else $error("trigger not one with fifo off");
  chk_dma_gate: assert property (RX_DMA_REQ == (DMA_MODE && RX_TRIG_HIT) && TX_DMA_REQ == (DMA_MODE && TX_TRIG_HIT))
    else $error("dma request gating wrong");
  chk_rx_hit: assert property ($stable(RX_TRIGGER) |-> RX_TRIG_HIT == ($past(RX_FILL) >= RX_TRIGGER))
    else $error("receive hit wrong");
  chk_halt_rise: assert property ($rose(RTS_HALT) && $stable(RX_TRIGGER) |-> $past(RX_FILL) >= RX_TRIGGER)
    else $error("halt below trigger");
  chk_halt_fall: assert property ($fell(RTS_HALT) && $stable(RX_TRIGGER) |-> $past(RX_FILL) <= RX_TRIGGER)
    else $error("resume above trigger");
  chk_xoff_level: assert property (XOFF_REQ && $stable(RX_TRIGGER) |-> $past(RX_FILL) == RX_TRIGGER)
    else $error("xoff not at trigger");
  chk_break_low: assert property ($rose(TXD) |-> $past(TX_SERIAL))
    else $error("line high without serial high");
  chk_tick_gap: assert property (!PRESCALE_TICK [*3] |=> PRESCALE_TICK)
    else $error("prescale gap too long");
endmodule // uart_flc_props

bind uart_fifo_line_control uart_flc_props u_props (.CLOCK, .RST, .ADDRESS, .WRITE, .BYTEENABLE,
  .WRITEDATA, .WAITREQUEST, .RX_FILL, .RX_FIFO_CLR, .TX_FIFO_CLR, .FIFO_ENABLE, .FIFO_DEPTH,
  .RX_TRIGGER, .TX_TRIGGER, .RX_TRIG_HIT, .TX_TRIG_HIT, .DMA_MODE, .RX_DMA_REQ, .TX_DMA_REQ,
  .RTS_HALT, .XOFF_REQ, .TX_SERIAL, .TXD, .PRESCALE_TICK);

// *** tb/uart_flc_remote.sv ***
/*
  Remote serial device feeding the receive FIFO and serial data.
  Assumes the bench sets the fill goal and pace.
*/
`timescale 1ns/1ps
module uart_flc_remote (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Bench control
  input  wire logic [6:0] goal,
  input  wire logic       slow,
  // From the block
  input  wire logic       RTS_HALT,
  // To the block
  output logic      [6:0] RX_FILL,
  output logic      [6:0] TX_FILL,
  output logic            TX_SERIAL,
  output logic      [7:0] RX_CHAR,
  output logic            RX_PARITY
);
  integer seed = 32'h79DF;
  logic   pace_r;
  wire    step = !slow || pace_r;
  always_ff @(posedge CLOCK or posedge RST)
    if (RST)
    begin
      RX_FILL   <= 7'h00;
      TX_FILL   <= 7'h00;
      TX_SERIAL <= 1'b1;
      RX_CHAR   <= 8'h00;
      RX_PARITY <= 1'b0;
      pace_r    <= 1'b0;
    end
    else
    begin
      pace_r    <= !pace_r;
      TX_FILL   <= {1'b0, 6'($random(seed))};
      TX_SERIAL <= 1'($random(seed));
      RX_CHAR   <= 8'($random(seed));
      RX_PARITY <= 1'($random(seed));
      // Sender stops while halted
      if (step && RX_FILL < goal && !RTS_HALT)
        RX_FILL <= RX_FILL + 7'h01;
      else if (step && RX_FILL > goal)
        RX_FILL <= RX_FILL - 7'h01;
    end
endmodule // uart_flc_remote
